// [hw/spi_pin_ctrl.sv]
/*
  Pin direction, mode-fault detection and fault recovery of the serial port.
  Assumes a shift engine and baud generator outside that supply the serial
  clock level and transmit bit; pins are resolved from the enables outside.
*/
module spi_pin_ctrl
(
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        link_clk_i,
  input  wire logic                        ctrl_wr_i,
  input  wire spi_pkg::ctrl_type           ctrl_i,
  input  wire logic                        status_rd_i,
  input  wire logic                        xfer_start_i,
  input  wire logic                        xfer_done_i,
  input  wire logic                        sck_gen_i,
  input  wire logic                        tx_bit_i,
  input  wire logic                        ss_i,
  input  wire logic                        mosi_i,
  input  wire logic                        miso_i,
  output spi_pkg::ctrl_type                ctrl_o,
  output logic                             mode_fault_flag_o,
  output logic                             busy_o,
  output logic                             abort_o,
  output logic                             rx_bit_o,
  output logic [spi_pkg::BYTE_BITS-1:0]    rx_byte_o,
  output logic                             rx_valid_o,
  output logic                             sck_o,
  output logic                             sck_oe_n_o,
  output logic                             ss_o,
  output logic                             ss_oe_n_o,
  output logic                             mosi_o,
  output logic                             mosi_oe_n_o,
  output logic                             miso_o,
  output logic                             miso_oe_n_o
);
  import spi_pkg::*;

  ctrl_type             ctrl_reg;
  logic                 mode_fault_flag_reg;
  logic                 armed_reg;
  xfer_state_type       state_reg;
  pin_drv_type          pins_reg;
  pin_drv_type          pins_next;
  logic                 ss_meta_reg;
  logic                 ss_sync_reg;
  logic                 mosi_meta_reg;
  logic                 mosi_sync_reg;
  logic                 miso_meta_reg;
  logic                 miso_sync_reg;
  logic                 tgl_meta_reg;
  logic                 tgl_sync_reg;
  logic                 tgl_seen_reg;
  logic                 abort_reg;
  logic                 rx_bit_reg;
  logic                 rx_bit_next;
  logic [BYTE_BITS-1:0] rx_byte_reg;
  logic                 rx_valid_reg;
  logic [BYTE_BITS-1:0] link_byte;
  logic                 link_tgl;
  logic                 link_rst;
  logic                 fault_set;
  logic                 detect_off;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ss_meta_reg   <= 1'b1;
      ss_sync_reg   <= 1'b1;
      mosi_meta_reg <= 1'b0;
      mosi_sync_reg <= 1'b0;
      miso_meta_reg <= 1'b0;
      miso_sync_reg <= 1'b0;
    end
    else
    begin
      ss_meta_reg   <= ss_i;
      ss_sync_reg   <= ss_meta_reg;
      mosi_meta_reg <= mosi_i;
      mosi_sync_reg <= mosi_meta_reg;
      miso_meta_reg <= miso_i;
      miso_sync_reg <= miso_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Mode fault detection
  // ----------------------------------------------------------------
  // A low select seen by an enabled master with detection on is a fault.
  assign fault_set  = ctrl_reg.spi_enable & ctrl_reg.master &
                      ctrl_reg.mode_fault_detect_enable & ~ss_sync_reg; // see [R7]
  // A slave never reaches fault_set because master is part of the term.
  assign detect_off = ctrl_reg.master & ~ctrl_reg.mode_fault_detect_enable; // see [R8]

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // The fault wins over a write in the same cycle, so a second master can
  // never be overruled by a late software write.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_reg <= CTRL_RESET;
    end
    else if (fault_set)
    begin
      ctrl_reg.master              <= 1'b0; // see [R10]
      ctrl_reg.bidir_output_enable <= 1'b0; // see [R12]
    end
    else if (ctrl_wr_i)
    begin
      ctrl_reg <= ctrl_i;
    end
  end

  // ----------------------------------------------------------------
  // Mode fault flag and its clearing sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode_fault_flag_reg <= 1'b0; // see [R15]
    end
    else if (fault_set)
    begin
      mode_fault_flag_reg <= 1'b1; // see [R7]
    end
    else if (detect_off)
    begin
      mode_fault_flag_reg <= 1'b0; // see [R8]
    end
    else if (armed_reg && ctrl_wr_i)
    begin
      mode_fault_flag_reg <= 1'b0; // see [R13]
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      armed_reg <= 1'b0; // see [R15]
    end
    else if (status_rd_i && mode_fault_flag_reg)
    begin
      armed_reg <= 1'b1; // see [R13]
    end
    else if (ctrl_wr_i || !mode_fault_flag_reg)
    begin
      armed_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transfer state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_IDLE;
      abort_reg <= 1'b0;
    end
    else
    begin
      abort_reg <= fault_set && (state_reg == ST_BUSY);
      if (fault_set)
      begin
        state_reg <= ST_IDLE; // see [R11]
      end
      else
      begin
        case (state_reg)
          ST_IDLE:
          begin
            if (xfer_start_i && ctrl_reg.spi_enable && !mode_fault_flag_reg)
            begin
              state_reg <= ST_BUSY; // see [R14]
            end
          end
          ST_BUSY:
          begin
            if (xfer_done_i || !ctrl_reg.spi_enable)
            begin
              state_reg <= ST_IDLE;
            end
          end
          default:
          begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin direction
  // ----------------------------------------------------------------
  always_comb
  begin
    pins_next   = PINS_RESET;
    rx_bit_next = mosi_sync_reg;
    // The flag keeps every output released until software clears it.
    if (ctrl_reg.spi_enable && !mode_fault_flag_reg) // see [R10] [R14]
    begin
      if (ctrl_reg.master)
      begin
        pins_next.sck      = sck_gen_i;
        pins_next.sck_oe_n = 1'b0; // see [R3] [R5]
        if (ctrl_reg.ss_output_enable && !ctrl_reg.mode_fault_detect_enable)
        begin
          pins_next.ss      = state_reg != ST_BUSY;
          pins_next.ss_oe_n = 1'b0; // see [R4] [R5]
        end
        pins_next.mosi = tx_bit_i; // see [R2]
        if (ctrl_reg.bidir_mode)
        begin
          pins_next.mosi_oe_n = ~ctrl_reg.bidir_output_enable; // see [R1]
          rx_bit_next         = mosi_sync_reg; // see [R2]
        end
        else
        begin
          pins_next.mosi_oe_n = 1'b0;
          rx_bit_next         = miso_sync_reg;
        end
      end
      else
      begin
        pins_next.miso = tx_bit_i; // see [R2]
        if (ctrl_reg.bidir_mode)
        begin
          pins_next.miso_oe_n = ~ctrl_reg.bidir_output_enable; // see [R1] [R6]
          rx_bit_next         = miso_sync_reg; // see [R6]
        end
        else
        begin
          pins_next.miso_oe_n = ss_sync_reg; // see [R9]
          rx_bit_next         = mosi_sync_reg;
        end
      end
    end
    else if (ctrl_reg.bidir_mode)
    begin
      // A demoted single-wire master listens on MISO from now on.
      rx_bit_next = miso_sync_reg; // see [R6]
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pins_reg   <= PINS_RESET;
      rx_bit_reg <= 1'b0;
    end
    else
    begin
      pins_reg   <= pins_next;
      rx_bit_reg <= rx_bit_next;
    end
  end

  // ----------------------------------------------------------------
  // Receive side on the serial clock
  // ----------------------------------------------------------------
  // The select pin ends a frame even when the far clock has stopped.
  assign link_rst = rst_i | ss_i;

  spi_link_rx u_link_rx
  (
    .link_clk_i  (link_clk_i),
    .link_rst_i  (rst_i),
    .frame_rst_i (link_rst),
    .serial_i    (ctrl_reg.bidir_mode ? miso_i : mosi_i),
    .byte_o      (link_byte),
    .byte_tgl_o  (link_tgl)
  );

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tgl_meta_reg <= 1'b0;
      tgl_sync_reg <= 1'b0;
      tgl_seen_reg <= 1'b0;
      rx_byte_reg  <= '0;
      rx_valid_reg <= 1'b0;
    end
    else
    begin
      tgl_meta_reg <= link_tgl;
      tgl_sync_reg <= tgl_meta_reg;
      tgl_seen_reg <= tgl_sync_reg;
      rx_valid_reg <= 1'b0;
      // Bytes are only taken in the slave role; a master's bytes come
      // from its own shift engine.
      if ((tgl_sync_reg != tgl_seen_reg) && !ctrl_reg.master)
      begin
        rx_byte_reg  <= link_byte;
        rx_valid_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ctrl_o            = ctrl_reg;
  assign mode_fault_flag_o = mode_fault_flag_reg;
  assign busy_o            = state_reg == ST_BUSY;
  assign abort_o           = abort_reg;
  assign rx_bit_o          = rx_bit_reg;
  assign rx_byte_o         = rx_byte_reg;
  assign rx_valid_o        = rx_valid_reg;
  assign sck_o             = pins_reg.sck;
  assign sck_oe_n_o        = pins_reg.sck_oe_n;
  assign ss_o              = pins_reg.ss;
  assign ss_oe_n_o         = pins_reg.ss_oe_n;
  assign mosi_o            = pins_reg.mosi;
  assign mosi_oe_n_o       = pins_reg.mosi_oe_n;
  assign miso_o            = pins_reg.miso;
  assign miso_oe_n_o       = pins_reg.miso_oe_n;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_fault_taken;
    fault_set ##1 mode_fault_flag_reg;
  endsequence

  sequence s_read_then_write;
    (status_rd_i && mode_fault_flag_reg && !ctrl_wr_i) ##1 (ctrl_wr_i && !fault_set);
  endsequence

  property p_fault_sets_flag;
    @(posedge clk_i) disable iff (rst_i)
    fault_set |=> mode_fault_flag_reg;
  endproperty
  a_fault_sets_flag: assert property (p_fault_sets_flag) // see [R7]
    else $error("Low select on a detecting master did not set the flag.");

  property p_detect_off_clear;
    @(posedge clk_i) disable iff (rst_i)
    detect_off |=> !mode_fault_flag_reg;
  endproperty
  a_detect_off_clear: assert property (p_detect_off_clear) // see [R8]
    else $error("Flag set while detection was off.");

  property p_slave_no_fault;
    @(posedge clk_i) disable iff (rst_i)
    (!ctrl_reg.master && !mode_fault_flag_reg) |=> !mode_fault_flag_reg;
  endproperty
  a_slave_no_fault: assert property (p_slave_no_fault) // see [R9]
    else $error("Slave raised a mode fault.");

  property p_fault_demotes;
    @(posedge clk_i) disable iff (rst_i)
    fault_set |=> (!ctrl_reg.master && !ctrl_reg.bidir_output_enable);
  endproperty
  a_fault_demotes: assert property (p_fault_demotes) // see [R10] [R12]
    else $error("Fault left master or output enable set.");

  property p_fault_releases_pins;
    @(posedge clk_i) disable iff (rst_i)
    s_fault_taken |=> (sck_oe_n_o && mosi_oe_n_o && miso_oe_n_o);
  endproperty
  a_fault_releases_pins: assert property (p_fault_releases_pins) // see [R10]
    else $error("A pin was still driven after a mode fault.");

  property p_fault_idle;
    @(posedge clk_i) disable iff (rst_i)
    fault_set |=> (!busy_o ##1 !busy_o);
  endproperty
  a_fault_idle: assert property (p_fault_idle) // see [R11]
    else $error("Transfer not aborted by a mode fault.");

  property p_read_write_clears;
    @(posedge clk_i) disable iff (rst_i)
    s_read_then_write |=> !mode_fault_flag_reg;
  endproperty
  a_read_write_clears: assert property (p_read_write_clears) // see [R13]
    else $error("Read then write did not clear the flag.");

  property p_write_alone_keeps;
    @(posedge clk_i) disable iff (rst_i)
    (mode_fault_flag_reg && ctrl_wr_i && !armed_reg && !detect_off) |=> mode_fault_flag_reg;
  endproperty
  a_write_alone_keeps: assert property (p_write_alone_keeps) // see [R13]
    else $error("Flag cleared without a prior status read.");

  property p_resume_master;
    @(posedge clk_i) disable iff (rst_i)
    (!mode_fault_flag_reg && ctrl_reg.master && ctrl_reg.spi_enable) |=> !sck_oe_n_o;
  endproperty
  a_resume_master: assert property (p_resume_master) // see [R14] [R3]
    else $error("Master did not drive the clock once the flag was clear.");

  property p_bidir_dir;
    @(posedge clk_i) disable iff (rst_i)
    (ctrl_reg.spi_enable && !mode_fault_flag_reg && ctrl_reg.master && ctrl_reg.bidir_mode)
      |=> (mosi_oe_n_o == !$past(ctrl_reg.bidir_output_enable));
  endproperty
  a_bidir_dir: assert property (p_bidir_dir) // see [R1]
    else $error("Single-wire data pin direction does not follow the enable.");

  property p_slave_inputs;
    @(posedge clk_i) disable iff (rst_i)
    !ctrl_reg.master |=> (sck_oe_n_o && ss_oe_n_o);
  endproperty
  a_slave_inputs: assert property (p_slave_inputs) // see [R3] [R4]
    else $error("Slave drove the clock or select pin.");

  property p_demoted_bidir_miso;
    @(posedge clk_i) disable iff (rst_i)
    (fault_set && ctrl_reg.bidir_mode) |-> ##2 (mosi_oe_n_o && rx_bit_o == $past(miso_sync_reg));
  endproperty
  a_demoted_bidir_miso: assert property (p_demoted_bidir_miso) // see [R6]
    else $error("Demoted single-wire master did not move to MISO.");

endmodule

// [hw/spi_pkg.sv]
/*
  Shared types and constants for the serial port pin-direction and mode-fault logic.
  Assumes one system clock domain plus a serial clock that the far master drives
  while this end is a slave.
*/
// What this block does
// [R1] In single-wire mode the direction of the one data pin follows the bidir_output_enable bit.
// [R2] A data pin set as output carries the shift data; in single-wire mode that same pin feeds the serial input.
// [R3] The serial clock pin is driven as master and is only an input as slave.
// [R4] The select pin may be input or output as master and is always an input as slave.
// [R5] Single-wire mode leaves the clock and select pin behaviour as in normal mode.
// [R6] A fault that demotes a single-wire master moves its data pin from MOSI to MISO.
// [R7] An enabled master with detection enabled sets mode_fault_flag whenever the select input is low.
// [R8] A master with detection disabled ignores the select pin and keeps the flag cleared.
// [R9] A slave treats select purely as an input and never raises a mode fault.
// [R10] A mode fault makes the device a slave with all of clock, MISO and MOSI released.
// [R11] A mode fault aborts any transfer and returns the transfer machine to idle.
// [R12] A mode fault on a single-wire master clears bidir_output_enable.
// [R13] The flag clears only after a status read that saw it set, then a control write, or while a master has detection disabled.
// [R14] Once the flag is clear the device works again as master or slave per its settings.
// [R15] Reset clears the flag and the clearing-sequence tracker.
package spi_pkg;

  // ----------------------------------------------------------------
  // Control and pin carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic spi_enable;
    logic master;
    logic mode_fault_detect_enable;
    logic ss_output_enable;
    logic bidir_mode;
    logic bidir_output_enable;
  } ctrl_type;

  typedef struct packed {
    logic sck;
    logic sck_oe_n;
    logic mosi;
    logic mosi_oe_n;
    logic miso;
    logic miso_oe_n;
    logic ss;
    logic ss_oe_n;
  } pin_drv_type;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam ctrl_type    CTRL_RESET = 6'h00;
  localparam pin_drv_type PINS_RESET = 8'h55;
  localparam int          BYTE_BITS  = 8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } xfer_state_type;

endpackage

// [hw/spi_link_rx.sv]
/*
  Receive capture in the serial clock's own domain.
  Assumes the far master's clock only toggles while select is low; select high
  ends the frame and clears the partial byte asynchronously. The finished byte
  and its toggle clear only on system reset, so a frame end never looks like a
  new byte to the system side.
*/
module spi_link_rx
  import spi_pkg::*;
(
  input  wire logic                  link_clk_i,
  input  wire logic                  link_rst_i,
  input  wire logic                  frame_rst_i,
  input  wire logic                  serial_i,
  output logic [BYTE_BITS-1:0]       byte_o,
  output logic                       byte_tgl_o
);

  logic [BYTE_BITS-1:0] shift_reg;
  logic [2:0]           count_reg;

  // ----------------------------------------------------------------
  // Shift
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk_i or posedge frame_rst_i)
  begin
    if (frame_rst_i)
    begin
      shift_reg <= '0;
      count_reg <= 3'h0;
    end
    else
    begin
      shift_reg <= {shift_reg[BYTE_BITS-2:0], serial_i};
      count_reg <= count_reg + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Byte hand-off
  // ----------------------------------------------------------------
  // The byte is held until the next one completes, which gives the
  // system side eight serial clocks to take it after the toggle.
  always_ff @(posedge link_clk_i or posedge link_rst_i)
  begin
    if (link_rst_i)
    begin
      byte_o     <= '0;
      byte_tgl_o <= 1'b0;
    end
    else if (count_reg == 3'h7)
    begin
      byte_o     <= {shift_reg[BYTE_BITS-2:0], serial_i};
      byte_tgl_o <= ~byte_tgl_o;
    end
  end

endmodule

// [tb/spi_far_end.sv]
/*
  Far-side model: another master or slave sharing the serial bus.
  Assumes the bench resolves every pin from all enables; data lines have no pull.
*/
module spi_far_end
(
  output logic sck_o,
  output logic ss_o,
  output logic mosi_o,
  output logic miso_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Idle state
  // ----------------------------------------------------------------
  // The clock stands still between frames and select rests high.
  initial
  begin
    sck_o  = 1'b0;
    ss_o   = 1'b1;
    mosi_o = 1'b0;
    miso_o = 1'b0;
  end

  // ----------------------------------------------------------------
  // Bus actions
  // ----------------------------------------------------------------
  task automatic pull_ss(input logic v);
    ss_o = v;
  endtask

  task automatic set_miso(input logic v);
    miso_o = v;
  endtask

  // One byte, most significant bit first, data set before each rising edge.
  task automatic send_byte(input logic [7:0] b);
    ss_o = 1'b0;
    #13;
    for (int i = 7; i >= 0; i--)
    begin
      mosi_o = b[i];
      #8 sck_o = 1'b1;
      #16 sck_o = 1'b0;
      #8;
    end
    #16 ss_o = 1'b1;
    // A released line shows the inverse so that a stale value cannot pass.
    mosi_o = ~mosi_o;
  endtask
endmodule

// [tb/test_spi_pin_ctrl.sv]
/*
  Self-checking bench for the pin-direction and mode-fault block.
  Assumes the far-end model drives select, link clock and data when released.
*/
module test_spi_pin_ctrl
  import spi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk_i, rst_i, ctrl_wr_i, status_rd_i, xfer_start_i, xfer_done_i;
  logic       sck_gen_i, tx_bit_i, flag, busy, abort, rx_bit, rx_valid;
  logic       sck_o, sck_oe_n, ss_o, ss_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
  logic       p_sck, p_ss, p_mosi, p_miso, sck_w, ss_w, mosi_w, miso_w, got;
  logic [7:0] rx_byte, oe;
  ctrl_type   ctrl_i, ctrl_o;
  int         miscompares, tests_run;

  // Each pin carries the device value while its enable is low.
  assign sck_w  = !sck_oe_n ? sck_o : p_sck;
  assign ss_w   = !ss_oe_n ? ss_o : p_ss;
  assign mosi_w = !mosi_oe_n ? mosi_o : p_mosi;
  assign miso_w = !miso_oe_n ? miso_o : p_miso;
  assign oe     = {4'h0, sck_oe_n, ss_oe_n, mosi_oe_n, miso_oe_n};

  spi_far_end fm (.sck_o(p_sck), .ss_o(p_ss), .mosi_o(p_mosi), .miso_o(p_miso));

  spi_pin_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(sck_w),
    .ctrl_wr_i(ctrl_wr_i), .ctrl_i(ctrl_i), .status_rd_i(status_rd_i),
    .xfer_start_i(xfer_start_i), .xfer_done_i(xfer_done_i), .sck_gen_i(sck_gen_i),
    .tx_bit_i(tx_bit_i), .ss_i(ss_w), .mosi_i(mosi_w), .miso_i(miso_w),
    .ctrl_o(ctrl_o), .mode_fault_flag_o(flag), .busy_o(busy), .abort_o(abort),
    .rx_bit_o(rx_bit), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
    .sck_o(sck_o), .sck_oe_n_o(sck_oe_n), .ss_o(ss_o), .ss_oe_n_o(ss_oe_n),
    .mosi_o(mosi_o), .mosi_oe_n_o(mosi_oe_n), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    if (miscompares == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Pins settle one edge after the write edge.
  task automatic wr(input ctrl_type c);
    ctrl_i    = c;
    ctrl_wr_i = 1'b1;
    cyc(1);
    ctrl_wr_i = 1'b0;
    cyc(2);
  endtask

  task automatic rd_status;
    status_rd_i = 1'b1;
    cyc(1);
    status_rd_i = 1'b0;
    cyc(1);
  endtask

  // The abort pulse stands only in the first cycle of the flag.
  task automatic wait_flag(input logic exp_abort);
    for (int i = 0; i < 20; i++)
    begin
      if (flag === 1'b1)
      begin
        chk("abort", {7'h00, abort}, {7'h00, exp_abort});
        return;
      end
      cyc(1);
    end
    miscompares++;
    tally_and_finish();
  endtask

  // Start and end pulses of a transfer, each followed by one settling cycle.
  task automatic start_xfer;
    xfer_start_i = 1'b1;
    cyc(1);
    xfer_start_i = 1'b0;
    cyc(1);
  endtask

  task automatic end_xfer;
    xfer_done_i = 1'b1;
    cyc(1);
    xfer_done_i = 1'b0;
    cyc(1);
  endtask

  // Select must reach the synchronised side before detection is enabled again.
  task automatic release_ss;
    fm.pull_ss(1'b1);
    cyc(2);
  endtask

  // ----------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial
  begin
    {ctrl_wr_i, status_rd_i, xfer_start_i, xfer_done_i, sck_gen_i, tx_bit_i} = 6'h00;
    ctrl_i = 6'h00;
    got    = 1'b0;
    rst_i  = 1'b1;
    cyc(16);
    rst_i = 1'b0;
    chk("reset oe", oe, 8'h0f);
    chk("reset flag", {7'h00, flag}, 8'h00);
    chk("reset ctrl", {2'h0, ctrl_o}, 8'h00);
    // Master with a driven select and detection off.
    wr(6'h34);
    chk("master oe", oe, 8'h01);
    for (int v = 0; v < 2; v++)
    begin
      sck_gen_i = v[0];
      tx_bit_i  = ~v[0];
      cyc(2);
      chk("sck out", {7'h00, sck_o}, {7'h00, v[0]});
      chk("mosi out", {7'h00, mosi_o}, {7'h00, ~v[0]});
    end
    // The driven select goes low for the length of a transfer.
    start_xfer();
    chk("ss busy", {7'h00, ss_o}, 8'h00);
    end_xfer();
    chk("ss idle", {7'h00, ss_o}, 8'h01);
    // Detection off: a low select is ignored.
    wr(6'h30);
    fm.pull_ss(1'b0);
    cyc(8);
    chk("no fault", {7'h00, flag}, 8'h00);
    release_ss();
    // A plain transfer starts and ends on its pulses.
    wr(6'h38);
    start_xfer();
    chk("busy", {7'h00, busy}, 8'h01);
    end_xfer();
    chk("idle", {7'h00, busy}, 8'h00);
    // Fault in mid-transfer.
    start_xfer();
    fm.pull_ss(1'b0);
    wait_flag(1'b1);
    chk("busy cut", {7'h00, busy}, 8'h00);
    chk("demoted", {2'h0, ctrl_o}, 8'h28);
    cyc(1);
    chk("released", oe, 8'h0f);
    release_ss();
    // A write without an armed read leaves the flag set.
    wr(6'h38);
    chk("unarmed", {7'h00, flag}, 8'h01);
    rd_status();
    wr(6'h38);
    chk("cleared", {7'h00, flag}, 8'h00);
    chk("resumed", {4'h0, oe[3], oe[1:0]}, 8'h01);
    // Single-wire master: the data pin follows its direction bit.
    wr(6'h3a);
    chk("bidir in", {4'h0, oe[3], oe[1:0]}, 8'h03);
    wr(6'h3b);
    chk("bidir out", {4'h0, oe[3], oe[1:0]}, 8'h01);
    for (int v = 0; v < 2; v++)
    begin
      tx_bit_i = v[0];
      cyc(6);
      chk("loop in", {7'h00, rx_bit}, {7'h00, v[0]});
    end
    fm.pull_ss(1'b0);
    wait_flag(1'b0);
    chk("oe dropped", {2'h0, ctrl_o}, 8'h2a);
    cyc(1);
    chk("fault pins", oe, 8'h0f);
    release_ss();
    for (int v = 0; v < 2; v++)
    begin
      fm.set_miso(v[0]);
      cyc(6);
      chk("miso taken", {7'h00, rx_bit}, {7'h00, v[0]});
    end
    // Slave: select is an input only and never faults.
    rd_status();
    wr(6'h20);
    chk("slave flag", {7'h00, flag}, 8'h00);
    chk("slave oe", {4'h0, oe[3:2], 2'h0}, 8'h0c);
    fork
      fm.send_byte(8'ha5);
      for (int i = 0; i < 60 && !got; i++)
      begin
        cyc(1);
        if (rx_valid === 1'b1)
        begin
          got = 1'b1;
          chk("rx byte", rx_byte, 8'ha5);
          chk("miso drive", {6'h00, miso_oe_n, miso_o}, 8'h01);
        end
      end
    join
    if (!got)
      miscompares++;
    // A frame end must not hand over a second byte.
    for (int i = 0; i < 8; i++)
    begin
      cyc(1);
      chk("one byte", {7'h00, rx_valid}, 8'h00);
    end
    chk("slave no fault", {7'h00, flag}, 8'h00);
    // A reset in mid-run clears a pending fault and its armed read.
    wr(6'h38);
    fm.pull_ss(1'b0);
    wait_flag(1'b0);
    rd_status();
    rst_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
    chk("rerun flag", {7'h00, flag}, 8'h00);
    chk("rerun ctrl", {2'h0, ctrl_o}, 8'h00);
    chk("rerun oe", oe, 8'h0f);
    tally_and_finish();
  end
endmodule
